// *** core/eth_core_register_decoder.sv ***
// eth_core_register_decoder: word-addressed decoder for PCS, PHY, backplane and MAC groups
// assumes: software drives one read or write strobe per access, targets answer in one cycle
//
// Behaviour
// - each address selects one whole 32-bit word
// - writes to read-only fields are ignored
// - reserved reads return a fixed constant
// - reserved writes change no state
// - four regions: PCS, PHY, backplane, MAC
// - PCS: transceiver, lock status, bit error groups
// - single PCS words at fixed offsets
// - newer non-CAUI-4 builds forward PHY words unchanged
// - CAUI-4 or older family: PHY range reserved
// - no backplane option: 0x080-0x0FF reserved
// - backplane groups: top/FEC, autoneg, training
// - MAC: configuration, pause and upper groups, gap reserved
`timescale 1ns/1ps
module eth_core_register_decoder #(
    parameter logic FAMILY    = regdec_pkg::FAMILY_NEW, // device family
    parameter logic CAUI4     = 1'b0,                   // four-lane CAUI-4 build
    parameter logic HAS_KR4   = 1'b0                    // backplane variant present
) (
    input  wire logic        sys_clk_i,     // single clock
    input  wire logic        resetn_i,      // async, active low
    input  wire logic [15:0] addr_i,        // word address
    input  wire logic        read_i,        // read strobe
    input  wire logic        write_i,       // write strobe
    input  wire logic [31:0] wdata_i,       // write data
    output logic [31:0]      rdata_o,       // read data, registered
    output logic             rvalid_o,      // read data valid, one-cycle pulse
    output logic [11:0]      sel_o,         // one-hot group select, level while strobed
    output logic             tgt_read_o,    // read forwarded to selected group
    output logic             tgt_write_o,   // write forwarded to selected group
    output logic [15:0]      tgt_addr_o,    // word address passed unchanged
    output logic [31:0]      tgt_wdata_o,   // write data to target
    input  wire logic [31:0] tgt_rdata_i [12], // read data per group, same cycle
    input  wire logic [31:0] ro_mask_i [12],   // per group read-only bit mask
    output logic             rsvd_hit_o     // current access hit a reserved word
);
    // ------------------------------------------------------------
    // build-option enables
    // ------------------------------------------------------------
    logic phy_en;     // integrated PHY map visible
    logic [11:0] hit;         // raw range hits
    logic [15:0] lo [12];     // group lower bounds
    logic [15:0] hi [12];     // group upper bounds
    logic [11:0] en;          // group present
    logic        single_hit;  // one of the single PCS words
    // older family and four-lane build both leave the PHY window empty
    assign phy_en = (FAMILY == regdec_pkg::FAMILY_NEW) && !CAUI4;
    // ------------------------------------------------------------
    // group table
    // ------------------------------------------------------------
    // unused slots get an empty range (lo above hi) so they never hit
    always_comb begin
        lo = '{default: 16'hFFFF};
        hi = '{default: 16'h0000};
        en = 12'h000;
        lo[regdec_pkg::GRP_XCVR]      = regdec_pkg::PCS_XCVR_LO;
        hi[regdec_pkg::GRP_XCVR]      = regdec_pkg::PCS_XCVR_HI;
        lo[regdec_pkg::GRP_LOCK]      = regdec_pkg::PCS_LOCK_LO;
        hi[regdec_pkg::GRP_LOCK]      = regdec_pkg::PCS_LOCK_HI;
        lo[regdec_pkg::GRP_BERR]      = regdec_pkg::PCS_BERR_LO;
        hi[regdec_pkg::GRP_BERR]      = regdec_pkg::PCS_BERR_HI;
        lo[regdec_pkg::GRP_PHY]       = regdec_pkg::PHY_LO;
        hi[regdec_pkg::GRP_PHY]       = regdec_pkg::PHY_HI;
        lo[regdec_pkg::GRP_KR_TOP]    = regdec_pkg::KR_TOP_LO;
        hi[regdec_pkg::GRP_KR_TOP]    = regdec_pkg::KR_TOP_HI;
        lo[regdec_pkg::GRP_KR_AN]     = regdec_pkg::KR_AN_LO;
        hi[regdec_pkg::GRP_KR_AN]     = regdec_pkg::KR_AN_HI;
        lo[regdec_pkg::GRP_KR_LT]     = regdec_pkg::KR_LT_LO;
        hi[regdec_pkg::GRP_KR_LT]     = regdec_pkg::KR_LT_HI;
        lo[regdec_pkg::GRP_MAC_CFG]   = regdec_pkg::MAC_CFG_LO;
        hi[regdec_pkg::GRP_MAC_CFG]   = regdec_pkg::MAC_CFG_HI;
        lo[regdec_pkg::GRP_MAC_PAUSE] = regdec_pkg::MAC_PAUSE_LO;
        hi[regdec_pkg::GRP_MAC_PAUSE] = regdec_pkg::MAC_PAUSE_HI;
        // upper MAC and example space passes on from 0x118 upward
        lo[regdec_pkg::GRP_MAC_UPPER] = 16'h0118;
        hi[regdec_pkg::GRP_MAC_UPPER] = 16'hFFFF;
        en[regdec_pkg::GRP_XCVR]      = 1'b1;
        en[regdec_pkg::GRP_LOCK]      = 1'b1;
        en[regdec_pkg::GRP_BERR]      = 1'b1;
        en[regdec_pkg::GRP_PHY]       = phy_en;
        en[regdec_pkg::GRP_KR_TOP]    = HAS_KR4;
        en[regdec_pkg::GRP_KR_AN]     = HAS_KR4;
        en[regdec_pkg::GRP_KR_LT]     = HAS_KR4;
        en[regdec_pkg::GRP_MAC_CFG]   = 1'b1;
        en[regdec_pkg::GRP_MAC_PAUSE] = 1'b1;
        en[regdec_pkg::GRP_MAC_UPPER] = 1'b1;
    end
    // ------------------------------------------------------------
    // range comparators, one per ranged group; the none and single-word PCS slots are tied off
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_claim
            if (g == int'(regdec_pkg::GRP_NONE) || g == int'(regdec_pkg::GRP_PCS_SINGLE)) begin : g_off
                assign hit[g] = 1'b0;
            end else begin : g_on
                group_claim u_claim (
                    .addr_i (addr_i),
                    .lo_i   (lo[g]),
                    .hi_i   (hi[g]),
                    .en_i   (en[g]),
                    .hit_o  (hit[g])
                );
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // single-word PCS registers; 0x01C stays reserved
    // ------------------------------------------------------------
    always_comb begin
        case (addr_i)
            regdec_pkg::PCS_HW_ERROR,
            regdec_pkg::BER_MONITOR,
            regdec_pkg::TEST_MODE_SEL,
            regdec_pkg::TEST_PAT_CNT,
            regdec_pkg::PCS_LINK_FLT,
            regdec_pkg::PHY_RST_CTRL: single_hit = 1'b1;
            default:                  single_hit = 1'b0;
        endcase
    end
    // ------------------------------------------------------------
    // state: registered read answer
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] rdata;   // held read word
        logic        rvalid;  // read answer pulse
    } state_t;
    state_t st_r;   // registered state
    state_t st_nxt; // next state
    logic [11:0] sel;     // final one-hot select
    logic [31:0] rd_word; // selected read word
    // last matching group wins; harmless, the ranges never overlap
    always_comb begin
        sel = hit;
        sel[regdec_pkg::GRP_PCS_SINGLE] = single_hit;
        rd_word = regdec_pkg::RSVD_VALUE;
        for (int i = 0; i < 12; i++) begin
            if (sel[i]) begin
                rd_word = tgt_rdata_i[i];
            end
        end
        st_nxt        = st_r;
        st_nxt.rvalid = read_i;
        if (read_i) begin
            st_nxt.rdata = rd_word;
        end
    end
    // one register for the whole state
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    // ------------------------------------------------------------
    // outputs toward targets
    // ------------------------------------------------------------
    // reserved hits leave the mask clear, no write is forwarded then
    logic [31:0] ro_mask; // read-only bits of selected group
    always_comb begin
        ro_mask = 32'h0000_0000;
        for (int i = 0; i < 12; i++) begin
            if (sel[i]) begin
                ro_mask = ro_mask_i[i];
            end
        end
    end
    // target strobes only when a group claims the word; reserved writes stop here
    assign sel_o       = (read_i || write_i) ? sel : 12'h000;
    assign rsvd_hit_o  = (read_i || write_i) && (sel == 12'h000);
    assign tgt_read_o  = read_i && (sel != 12'h000);
    assign tgt_write_o = write_i && (sel != 12'h000);
    assign tgt_addr_o  = addr_i;
    // read-only bits carry back current contents so the field stays unchanged
    assign tgt_wdata_o = (wdata_i & ~ro_mask) | (rd_word & ro_mask);
    assign rdata_o     = st_r.rdata;
    assign rvalid_o    = st_r.rvalid;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    onehot_sel_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $onehot0(sel_o)) else $error("more than one group selected");
    rsvd_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (read_i && sel == 12'h000) |=> (rvalid_o && rdata_o == regdec_pkg::RSVD_VALUE))
        else $error("reserved read not constant");
    rsvd_write_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (write_i && sel == 12'h000) |-> !tgt_write_o) else $error("reserved write passed");
    kr_absent_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (!HAS_KR4 && addr_i >= 16'h0080 && addr_i <= 16'h00FF) |-> sel == 12'h000)
        else $error("backplane range not reserved");
    phy_map_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i inside {[16'h0040:16'h007F]}) |-> (sel[regdec_pkg::GRP_PHY] == phy_en))
        else $error("phy range decode wrong");
    gap_mac_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i inside {[16'h0104:16'h010F]}) |-> sel == 12'h000)
        else $error("mac gap not reserved");
    single_word_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i == 16'h001C) |-> sel == 12'h000) else $error("0x01C not reserved");
    ro_keep_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        tgt_write_o |-> ((tgt_wdata_o & ro_mask) == (rd_word & ro_mask)))
        else $error("read-only bits overwritten");
    rd_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        read_i |=> rvalid_o) else $error("read answer missing");
    kr_gap_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i inside {[16'h0080:16'h00AF]}) |-> sel == 12'h000)
        else $error("backplane low range not reserved");
    xcvr_route_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i inside {[16'h0000:16'h0009]}) |-> sel == 12'h002)
        else $error("transceiver words misrouted");
    pause_route_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (addr_i inside {[16'h0110:16'h0117]}) |-> sel == 12'h400)
        else $error("pause words misrouted");
    idle_sel_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !(read_i || write_i) |-> (sel_o == 12'h000 && !tgt_read_o && !tgt_write_o))
        else $error("select without strobe");
    rdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !read_i |=> $stable(rdata_o)) else $error("read word changed without read");
endmodule // eth_core_register_decoder

// *** core/regdec_pkg.sv ***
// regdec_pkg: word offsets, group codes and build options for the register decoder
// assumes: word-addressed control and status port, one 32-bit word per offset
package regdec_pkg;
    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 16;           // word address width
    localparam int          DATA_W        = 32;           // one whole word per offset
    localparam logic [31:0] RSVD_VALUE    = 32'h0000_0000; // fixed answer for reserved words
    localparam int          RD_LATENCY    = 1;            // cycles from read strobe to valid
    // ------------------------------------------------------------
    // family encodings
    // ------------------------------------------------------------
    localparam logic        FAMILY_OLD    = 1'b0;         // older family, no integrated PHY map
    localparam logic        FAMILY_NEW    = 1'b1;         // newer family, integrated PHY map
    // ------------------------------------------------------------
    // region boundaries (word offsets)
    // ------------------------------------------------------------
    localparam logic [15:0] PCS_XCVR_LO   = 16'h0000;
    localparam logic [15:0] PCS_XCVR_HI   = 16'h0009;
    localparam logic [15:0] PCS_LOCK_LO   = 16'h0010;
    localparam logic [15:0] PCS_LOCK_HI   = 16'h0014;
    localparam logic [15:0] PCS_BERR_LO   = 16'h0015;
    localparam logic [15:0] PCS_BERR_HI   = 16'h0016;
    localparam logic [15:0] PCS_HW_ERROR  = 16'h0017;
    localparam logic [15:0] BER_MONITOR   = 16'h0018;
    localparam logic [15:0] TEST_MODE_SEL = 16'h0019;
    localparam logic [15:0] TEST_PAT_CNT  = 16'h001A;
    localparam logic [15:0] PCS_LINK_FLT  = 16'h001B;
    localparam logic [15:0] PHY_RST_CTRL  = 16'h001D;
    localparam logic [15:0] PHY_LO        = 16'h0040;
    localparam logic [15:0] PHY_HI        = 16'h007F;
    localparam logic [15:0] KR_TOP_LO     = 16'h00B0;
    localparam logic [15:0] KR_TOP_HI     = 16'h00BD;
    localparam logic [15:0] KR_AN_LO      = 16'h00C0;
    localparam logic [15:0] KR_AN_HI      = 16'h00CC;
    localparam logic [15:0] KR_LT_LO      = 16'h00D0;
    localparam logic [15:0] KR_LT_HI      = 16'h00EB;
    localparam logic [15:0] MAC_CFG_LO    = 16'h0100;
    localparam logic [15:0] MAC_CFG_HI    = 16'h0103;
    localparam logic [15:0] MAC_PAUSE_LO  = 16'h0110;
    localparam logic [15:0] MAC_PAUSE_HI  = 16'h0117;
    // ------------------------------------------------------------
    // target groups, one-hot select positions
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        GRP_NONE      = 4'h0,
        GRP_XCVR      = 4'h1,
        GRP_LOCK      = 4'h2,
        GRP_BERR      = 4'h3,
        GRP_PCS_SINGLE= 4'h4,
        GRP_PHY       = 4'h5,
        GRP_KR_TOP    = 4'h6,
        GRP_KR_AN     = 4'h7,
        GRP_KR_LT     = 4'h8,
        GRP_MAC_CFG   = 4'h9,
        GRP_MAC_PAUSE = 4'hA,
        GRP_MAC_UPPER = 4'hB
    } group_t;
    localparam int          NUM_GRP       = 12;           // select vector width
endpackage

// *** core/group_claim.sv ***
// group_claim: one range comparator that says whether a word address falls in a group
// assumes: bounds are inclusive word offsets, enable folds in the build option
`timescale 1ns/1ps
module group_claim (
    input  wire logic [15:0] addr_i,  // word address under decode
    input  wire logic [15:0] lo_i,    // first word of the group
    input  wire logic [15:0] hi_i,    // last word of the group
    input  wire logic        en_i,    // group present in this build
    output logic             hit_o    // address claimed by the group
);
    // ------------------------------------------------------------
    // inclusive range compare
    // ------------------------------------------------------------
    assign hit_o = en_i && (addr_i >= lo_i) && (addr_i <= hi_i);
endmodule // group_claim

// *** verification/target_groups.sv ***
// target_groups: behavioural stand-in for the twelve register groups behind the decoder
// assumes: one word of storage per group, read data offered every cycle, fixed read-only mask
`timescale 1ns/1ps
module target_groups (
    input  wire logic        sys_clk_i,     // single clock
    input  wire logic        resetn_i,      // async, active low
    input  wire logic [11:0] sel_i,         // one-hot group select
    input  wire logic        write_i,       // forwarded write strobe
    input  wire logic [31:0] wdata_i,       // merged write data
    output logic      [31:0] rdata_o [12],  // read word per group
    output logic      [31:0] ro_mask_o [12] // read-only bits per group
);
    // ------------------------------------------------------------
    // storage: distinct reset words so a wrong route shows up
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 12; i++) begin
                rdata_o[i] <= 32'hC0DE_0000 | 32'(i);
            end
        end else begin
            for (int i = 0; i < 12; i++) begin
                if (write_i && sel_i[i]) begin
                    rdata_o[i] <= wdata_i; // whole word only
                end
            end
        end
    end
    // upper half read-only everywhere, keeps the merge check simple
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            ro_mask_o[i] = 32'hFFFF_0000;
        end
    end
endmodule // target_groups

// *** verification/testbench.sv ***
// testbench: map walk, read-only merge and reserved write checks for the decoder
// assumes: default build on uut, a second build with CAUI-4 and backplane beside it
`timescale 1ns/1ps
module testbench;
    logic        sys_clk;    // 200 MHz clock
    logic        resetn;     // active-low reset
    logic [15:0] addr;       // word address
    logic        rd;         // read strobe
    logic        wr;         // write strobe
    logic [31:0] wdata;      // write data
    logic [31:0] rdata;      // registered read word
    logic        rvalid;     // read valid pulse
    logic [11:0] sel;        // group select
    logic [11:0] alt_sel;    // group select, alternate build
    logic        t_rd;       // forwarded read
    logic        t_wr;       // forwarded write
    logic [15:0] t_addr;     // forwarded address
    logic [31:0] t_wdata;    // merged write data
    logic [31:0] g_rdata [12]; // group read words
    logic [31:0] g_mask [12];  // group read-only masks
    logic        rsvd;       // reserved hit
    logic        alt_rsvd;   // reserved hit, alternate build
    logic [11:0] old_sel;    // group select, older-family build
    logic        old_rsvd;   // reserved hit, older-family build
    int          fails = 0;
    int          samples_checked = 0;
    // {addr, group in default build, group in caui-4 + backplane build}
    localparam logic [23:0] MAP [34] = '{
        24'h000011, 24'h000911, 24'h000A00, 24'h001022, 24'h001422, 24'h001533, 24'h001633,
        24'h001744, 24'h001A44, 24'h001B44, 24'h001C00, 24'h001D44, 24'h001E00, 24'h004050,
        24'h007F50, 24'h008000, 24'h00AF00, 24'h00B006, 24'h00BD06, 24'h00BE00, 24'h00C007,
        24'h00CC07, 24'h00CD00, 24'h00D008, 24'h00EB08, 24'h00EC00, 24'h00FF00, 24'h010099,
        24'h010399, 24'h010400, 24'h010F00, 24'h0110AA, 24'h0117AA, 24'h0118BB};
    // ------------------------------------------------------------
    // clock, units under test, partner
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    eth_core_register_decoder uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr),
        .read_i(rd), .write_i(wr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
        .sel_o(sel), .tgt_read_o(t_rd), .tgt_write_o(t_wr), .tgt_addr_o(t_addr),
        .tgt_wdata_o(t_wdata), .tgt_rdata_i(g_rdata), .ro_mask_i(g_mask), .rsvd_hit_o(rsvd));
    // alt and old builds: only selects and reserved flags compared, absent-register data is undefined
    eth_core_register_decoder #(.CAUI4(1'b1), .HAS_KR4(1'b1)) uut_alt (.sys_clk_i(sys_clk),
        .resetn_i(resetn), .addr_i(addr), .read_i(rd), .write_i(wr), .wdata_i(wdata),
        .rdata_o(), .rvalid_o(), .sel_o(alt_sel), .tgt_read_o(), .tgt_write_o(),
        .tgt_addr_o(), .tgt_wdata_o(), .tgt_rdata_i(g_rdata), .ro_mask_i(g_mask),
        .rsvd_hit_o(alt_rsvd));
    // older family: PHY window must read as reserved
    eth_core_register_decoder #(.FAMILY(regdec_pkg::FAMILY_OLD)) uut_old (.sys_clk_i(sys_clk),
        .resetn_i(resetn), .addr_i(addr), .read_i(rd), .write_i(wr), .wdata_i(wdata),
        .rdata_o(), .rvalid_o(), .sel_o(old_sel), .tgt_read_o(), .tgt_write_o(),
        .tgt_addr_o(), .tgt_wdata_o(), .tgt_rdata_i(g_rdata), .ro_mask_i(g_mask),
        .rsvd_hit_o(old_rsvd));
    target_groups model (.sys_clk_i(sys_clk), .resetn_i(resetn), .sel_i(sel), .write_i(t_wr),
        .wdata_i(t_wdata), .rdata_o(g_rdata), .ro_mask_o(g_mask));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    function automatic logic [11:0] onehot(input logic [3:0] g);
        onehot = 12'h000;
        if (g != 4'h0) onehot[g] = 1'b1;
    endfunction
    // one read: selects checked while strobed, data the cycle after
    task automatic do_read(input logic [15:0] a, input logic [3:0] g, input logic [3:0] ga,
                           input logic [31:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        #1;
        chk(sel === onehot(g) && rsvd === (g == 4'h0), "select wrong");
        chk(alt_sel === onehot(ga) && alt_rsvd === (ga == 4'h0), "alt select wrong");
        chk(old_sel === ((g == 4'h5) ? 12'h000 : onehot(g)), "old select wrong");
        chk(old_rsvd === (g == 4'h0 || g == 4'h5), "old reserved wrong");
        chk(t_rd === (g != 4'h0) && t_addr === a, "forward wrong");
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(rvalid === 1'b1 && rdata === exp, "read data wrong");
    endtask
    task automatic do_write(input logic [15:0] a, input logic [31:0] d, input logic fwd);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        #1;
        chk(t_wr === fwd && rsvd === !fwd, "write forward wrong");
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_map();
        logic [31:0] e;
        foreach (MAP[i]) begin
            e = (MAP[i][7:4] == 4'h0) ? regdec_pkg::RSVD_VALUE : 32'hC0DE_0000 | MAP[i][7:4];
            do_read(MAP[i][23:8], MAP[i][7:4], MAP[i][3:0], e);
        end
        $display("test map done");
    endtask
    task automatic t_read_only();
        do_write(16'h0018, 32'hAAAA_5555, 1'b1);
        do_read(16'h0018, 4'h4, 4'h4, 32'hC0DE_5555);
        $display("test read_only done");
    endtask
    task automatic t_rsvd_write();
        do_write(16'h001C, 32'h1234_5678, 1'b0);
        do_write(16'h0080, 32'h1234_5678, 1'b0);
        do_read(16'h001D, 4'h4, 4'h4, 32'hC0DE_5555);
        $display("test rsvd_write done");
    endtask
    // mid-run reset: read word cleared, group contents back to reset words
    task automatic t_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        chk(rdata === 32'h0000_0000 && rvalid === 1'b0, "reset state wrong");
        do_read(16'h001D, 4'h4, 4'h4, 32'hC0DE_0004);
        $display("test reset done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        addr   = 16'h0000;
        rd     = 1'b0;
        wr     = 1'b0;
        wdata  = 32'h0000_0000;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        t_map();
        t_read_only();
        t_rsvd_write();
        t_reset();
        end_sim();
    end
    initial begin
        #(5 * 2000);
        fails++;
        end_sim();
    end
endmodule // testbench
